// >>> bench/dspcg_assertions.sv
`timescale 1ns/1ps
module dspcg_chk (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire hce, // Clock enable
  input wire hsel, // Select
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire hready, // Bus ready
  input wire hreadyout_r, // Slave ready
  input wire hresp_r, // Response
  input wire sleep_req, // Sleep
  input wire deep_sleep_req, // Deep sleep
  input wire [31:0] unit_access, // Unit access
  input wire [31:0] unit_clk_en_r, // Unit enables
  input wire unit_fault_r // Fault pulse
);
  wire [31:0] hit = unit_access & ~unit_clk_en_r & 32'h0707_1013;
  wire req = hce && hsel && htrans[1] && hready;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  rsv_en_zero_a: assert property ((unit_clk_en_r & 32'hF8F8_EFEC) == 0)
    else $error("reserved enable set");
  fault_cause_a: assert property (unit_fault_r |-> $past(|hit))
    else $error("fault without gated access");
  fault_raise_a: assert property (hce && |hit |=> unit_fault_r)
    else $error("gated access without fault");
  no_fault_a: assert property (|unit_access && !(|hit) |=> !unit_fault_r)
    else $error("fault on clocked unit");
  reset_clear_a: assert property ($rose(hresetn) |-> unit_clk_en_r == 0)
    else $error("enables not cleared");
  resp_okay_a: assert property (hresp_r == 1'b0)
    else $error("response not okay");
  read_wait_a: assert property (req && !hwrite |=> !hreadyout_r ##1 hreadyout_r)
    else $error("read wait wrong");
  gate_hold_a: assert property ((!hsel && $stable(sleep_req) &&
    $stable(deep_sleep_req))[*3] |=> $stable(unit_clk_en_r))
    else $error("enables changed without cause");
endmodule // dspcg_chk
bind dspcg_top dspcg_chk dspcg_chk_i (.hclk(hclk), .hresetn(hresetn),
  .hce(hce), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout_r(hreadyout_r), .hresp_r(hresp_r),
  .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req),
  .unit_access(unit_access), .unit_clk_en_r(unit_clk_en_r),
  .unit_fault_r(unit_fault_r));

// >>> bench/tb_top.sv
`timescale 1ns/1ps
`include "dspcg_consts.vh"
module tb_top;
  logic hclk, hresetn, hce, hsel, hwrite, sleep_req, deep_sleep_req;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, unit_access, q;
  wire hready, hresp_r, unit_fault_r, irq_r;
  wire [31:0] hrdata_r, unit_clk_en_r;
  int errors, samples_checked;
  int bits[10] = '{0, 1, 4, 12, 16, 17, 18, 24, 25, 26};
  dspcg_top dspcg_top_i (.hclk(hclk), .hresetn(hresetn), .hce(hce),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout_r(hready),
    .hresp_r(hresp_r), .hrdata_r(hrdata_r), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .unit_access(unit_access),
    .unit_clk_en_r(unit_clk_en_r), .unit_fault_r(unit_fault_r),
    .irq_r(irq_r));
  task stop_test;
    $display("errors %0d checks %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask
  // Address phase held until ready, then data phase until ready again
  task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {20'h0, a};
    do @(posedge hclk); while (hready !== 1'b1 && n++ < 50);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1 && n++ < 50);
    q = hrdata_r;
    if (n > 50) begin
      chk(0, 1, "bus hang");
      stop_test;
    end
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(q, e, "read data");
  endtask
  task mode(input logic s, input logic d);
    sleep_req <= s;
    deep_sleep_req <= d;
    repeat (3) @(posedge hclk);
  endtask
  task pulse(input logic [31:0] v, input logic f);
    unit_access <= v;
    @(posedge hclk);
    unit_access <= 32'h0;
    @(negedge hclk);
    chk({31'h0, unit_fault_r}, {31'h0, f}, "fault pulse");
    repeat (3) @(posedge hclk);
  endtask
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  initial begin
    {hresetn, hsel, hwrite, sleep_req, deep_sleep_req, htrans} = 0;
    {haddr, hwdata, unit_access} = 0;
    hce = 1'b1;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`DSPCG_OFS_DEEP, 32'h0);
    chk(unit_clk_en_r, 32'h0, "enables after reset");
    foreach (bits[i]) begin
      bus(1'b1, `DSPCG_OFS_DEEP, 32'h1 << bits[i]);
      rd(`DSPCG_OFS_DEEP, 32'h1 << bits[i]);
    end
    bus(1'b1, `DSPCG_OFS_DEEP, 32'hFFFF_FFFF);
    rd(`DSPCG_OFS_DEEP, 32'h0707_1013);
    bus(1'b1, `DSPCG_OFS_DEEP, q & ~32'h1);
    rd(`DSPCG_OFS_DEEP, 32'h0707_1012);
    rd(12'h200, 32'h0);
    $display("field test done");
    bus(1'b1, `DSPCG_OFS_RUN, 32'h1);
    bus(1'b1, `DSPCG_OFS_SLEEP, 32'h10);
    bus(1'b1, `DSPCG_OFS_DEEP, 32'h1000);
    bus(1'b1, `DSPCG_OFS_CFG, 32'h1);
    mode(1'b1, 1'b0);
    chk(unit_clk_en_r, 32'h10, "sleep set");
    mode(1'b0, 1'b1);
    chk(unit_clk_en_r, 32'h1000, "deep set");
    rd(`DSPCG_OFS_MODE, 32'h2);
    rd(`DSPCG_OFS_EFF, 32'h1000);
    rd(`DSPCG_OFS_CFG, 32'h1);
    bus(1'b1, `DSPCG_OFS_CFG, 32'h0);
    mode(1'b0, 1'b1);
    chk(unit_clk_en_r, 32'h1, "auto gating off");
    mode(1'b0, 1'b0);
    $display("mode test done");
    pulse(32'h1, 1'b0);
    rd(`DSPCG_OFS_STAT, 32'h0);
    pulse(32'h1000, 1'b1);
    rd(`DSPCG_OFS_STAT, 32'h1000);
    chk({31'h0, irq_r}, 32'h0, "masked irq");
    bus(1'b1, `DSPCG_OFS_IEN, 32'h1000);
    rd(`DSPCG_OFS_IEN, 32'h1000);
    repeat (2) @(posedge hclk);
    chk({31'h0, irq_r}, 32'h1, "irq raised");
    bus(1'b1, `DSPCG_OFS_ICLR, 32'h1000);
    rd(`DSPCG_OFS_STAT, 32'h0);
    chk({31'h0, irq_r}, 32'h0, "irq cleared");
    $display("fault test done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd(`DSPCG_OFS_RUN, 32'h0);
    chk(unit_clk_en_r, 32'h0, "enables after reset");
    $display("reset test done");
    hce <= 1'b0;
    bus(1'b1, `DSPCG_OFS_RUN, 32'h1);
    pulse(32'h1000, 1'b0);
    hce <= 1'b1;
    rd(`DSPCG_OFS_RUN, 32'h0);
    rd(`DSPCG_OFS_STAT, 32'h0);
    $display("freeze test done");
    stop_test;
  end
endmodule // tb_top

// >>> logic/dspcg_consts.vh
`ifndef DSPCG_CONSTS_VH
`define DSPCG_CONSTS_VH

// Register byte offsets
`define DSPCG_OFS_CFG 12'h060
`define DSPCG_OFS_RUN 12'h100
`define DSPCG_OFS_SLEEP 12'h110
`define DSPCG_OFS_DEEP 12'h124
`define DSPCG_OFS_STAT 12'h140
`define DSPCG_OFS_IEN 12'h144
`define DSPCG_OFS_ICLR 12'h148
`define DSPCG_OFS_MODE 12'h14C
`define DSPCG_OFS_EFF 12'h150
`define DSPCG_ADDR_W 12

// Gate bit positions
`define DSPCG_BIT_ASER0 0
`define DSPCG_BIT_ASER1 1
`define DSPCG_BIT_SSER 4
`define DSPCG_BIT_TWB 12
`define DSPCG_BIT_TMR0 16
`define DSPCG_BIT_TMR1 17
`define DSPCG_BIT_TMR2 18
`define DSPCG_BIT_ACMP0 24
`define DSPCG_BIT_ACMP1 25
`define DSPCG_BIT_ACMP2 26

// Writable gate bits; every other bit is reserved and reads zero
`define DSPCG_GATE_MASK 32'h0707_1013
`define DSPCG_GATE_RST 32'h0000_0000
`define DSPCG_ZERO 32'h0000_0000

// Configuration register
`define DSPCG_CFG_AUTO_BIT 0

// Power modes
`define DSPCG_MODE_RUN 2'h0
`define DSPCG_MODE_SLEEP 2'h1
`define DSPCG_MODE_DEEP 2'h2

// AHB encodings
`define DSPCG_HTRANS_NONSEQ_BIT 1
`define DSPCG_HRESP_OKAY 1'b0

`endif

// >>> logic/dspcg_gate_reg.v
`timescale 1ns/1ps
`include "dspcg_consts.vh"
// Software register holding only the bits named in the mask
module dspcg_gate_reg #(
  parameter [31:0] MASK = `DSPCG_GATE_MASK,
  parameter [31:0] RST = `DSPCG_GATE_RST
) (
  input wire hclk, // System clock
  input wire hresetn, // Asynchronous reset, active low
  input wire ce, // Clock enable
  input wire we, // Write strobe
  input wire [31:0] wdata, // Write data
  output reg [31:0] q_r // Stored value
);

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q_r <= RST;
    end else if (ce && we) begin
      q_r <= wdata & MASK;
    end
  end

endmodule // dspcg_gate_reg

// >>> logic/dspcg_irq.v
`timescale 1ns/1ps
`include "dspcg_consts.vh"
// Sticky event status, enable and level interrupt
module dspcg_irq (
  input wire hclk, // System clock
  input wire hresetn, // Asynchronous reset, active low
  input wire ce, // Clock enable
  input wire [31:0] ev, // Event pulses
  input wire clr_we, // Write to clear register
  input wire en_we, // Write to enable register
  input wire [31:0] wdata, // Bus write data
  output reg [31:0] stat_r, // Sticky status
  output reg [31:0] en_r, // Interrupt enable
  output reg irq_r // Level interrupt
);

  reg [31:0] stat_nxt;
  reg [31:0] en_nxt;

  always @* begin
    stat_nxt = stat_r;
    en_nxt = en_r;
    if (clr_we) begin
      stat_nxt = stat_nxt & ~(wdata & `DSPCG_GATE_MASK);
    end
    // New events win over a clear in the same cycle
    stat_nxt = stat_nxt | (ev & `DSPCG_GATE_MASK);
    if (en_we) begin
      en_nxt = wdata & `DSPCG_GATE_MASK;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stat_r <= `DSPCG_ZERO;
      en_r <= `DSPCG_ZERO;
      irq_r <= 1'b0;
    end else if (ce) begin
      stat_r <= stat_nxt;
      en_r <= en_nxt;
      irq_r <= |(stat_nxt & en_nxt);
    end
  end

endmodule // dspcg_irq

// >>> logic/dspcg_top.v
// The AHB-Lite slave port is this design's own decision.
`timescale 1ns/1ps
`include "dspcg_consts.vh"
module dspcg_top (
  input wire hclk, // System clock, 40 MHz
  input wire hresetn, // Asynchronous reset, active low
  input wire hce, // Clock enable, freezes all state when low
  input wire hsel, // Slave select
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write when high
  input wire [2:0] hsize, // Transfer size, word only
  input wire [31:0] hwdata, // Write data
  input wire hready, // Bus ready
  output reg hreadyout_r, // Slave ready
  output reg hresp_r, // Response, always OKAY
  output reg [31:0] hrdata_r, // Read data
  input wire sleep_req, // Processor in sleep
  input wire deep_sleep_req, // Processor in deep sleep
  input wire [31:0] unit_access, // Access pulse per unit, gate layout
  output reg [31:0] unit_clk_en_r, // Clock enable per unit
  output reg unit_fault_r, // Bus fault pulse for a gated unit
  output reg irq_r // Interrupt, level
);

  localparam [1:0] ST_RUN = `DSPCG_MODE_RUN;
  localparam [1:0] ST_SLEEP = `DSPCG_MODE_SLEEP;
  localparam [1:0] ST_DEEP = `DSPCG_MODE_DEEP;

  reg [1:0] mode_r;
  reg [1:0] mode_nxt;
  reg wr_pend_r;
  reg rd_pend_r;
  reg [`DSPCG_ADDR_W-1:0] addr_r;
  reg [31:0] eff_nxt;
  reg [31:0] rd_mux;
  reg [31:0] cfg_r;
  reg [31:0] gate_nxt;
  reg wr_run;
  reg wr_sleep;
  reg wr_deep;
  reg wr_cfg;
  reg wr_ien;
  reg wr_iclr;
  wire [31:0] run_q;
  wire [31:0] sleep_q;
  wire [31:0] deep_q;
  wire [31:0] stat_q;
  wire [31:0] ien_q;
  wire irq_w;
  wire auto_gate;
  wire xfer;
  wire [31:0] fault_ev;

  assign xfer = hce && hsel && hready && htrans[`DSPCG_HTRANS_NONSEQ_BIT];
  assign auto_gate = cfg_r[`DSPCG_CFG_AUTO_BIT];

  // Read waits one cycle so a preceding write is already visible
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      hreadyout_r <= 1'b1;
      hrdata_r <= `DSPCG_ZERO;
    end else if (hce) begin
      if (rd_pend_r) begin
        hrdata_r <= rd_mux;
        hreadyout_r <= 1'b1;
        rd_pend_r <= 1'b0;
      end else if (xfer && !hwrite) begin
        rd_pend_r <= 1'b1;
        hreadyout_r <= 1'b0;
      end
      wr_pend_r <= xfer && hwrite;
    end
  end

  // Address of the transfer now in its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_r <= {`DSPCG_ADDR_W{1'b0}};
    end else if (hce && xfer) begin
      addr_r <= haddr[`DSPCG_ADDR_W-1:0];
    end
  end

  // Gated units fault on their own port, the bus always answers OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_r <= `DSPCG_HRESP_OKAY;
    end else if (hce) begin
      hresp_r <= `DSPCG_HRESP_OKAY;
    end
  end

  // Write strobes, valid in the data phase only
  always @* begin
    wr_run = 1'b0;
    wr_sleep = 1'b0;
    wr_deep = 1'b0;
    wr_cfg = 1'b0;
    wr_ien = 1'b0;
    wr_iclr = 1'b0;
    if (wr_pend_r) begin
      case (addr_r)
        `DSPCG_OFS_RUN: wr_run = 1'b1;
        `DSPCG_OFS_SLEEP: wr_sleep = 1'b1;
        `DSPCG_OFS_DEEP: wr_deep = 1'b1;
        `DSPCG_OFS_CFG: wr_cfg = 1'b1;
        `DSPCG_OFS_IEN: wr_ien = 1'b1;
        `DSPCG_OFS_ICLR: wr_iclr = 1'b1;
        default: wr_run = 1'b0;
      endcase
    end
  end

  // Three gate sets
  dspcg_gate_reg u_run (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hce),
    .we(wr_run),
    .wdata(hwdata),
    .q_r(run_q)
  );

  dspcg_gate_reg u_sleep (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hce),
    .we(wr_sleep),
    .wdata(hwdata),
    .q_r(sleep_q)
  );

  dspcg_gate_reg u_deep (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hce),
    .we(wr_deep),
    .wdata(hwdata),
    .q_r(deep_q)
  );

  // Automatic gating select; without it the run set applies
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_r <= `DSPCG_ZERO;
    end else if (hce && wr_cfg) begin
      cfg_r <= {31'h0000_0000, hwdata[`DSPCG_CFG_AUTO_BIT]};
    end
  end

  // Power mode tracker
  always @* begin
    case (mode_r)
      ST_RUN, ST_SLEEP, ST_DEEP: begin
        if (deep_sleep_req) begin
          mode_nxt = ST_DEEP;
        end else if (sleep_req) begin
          mode_nxt = ST_SLEEP;
        end else begin
          mode_nxt = ST_RUN;
        end
      end
      default: begin
        mode_nxt = ST_RUN;
      end
    endcase
  end

  // Active gate set by mode
  always @* begin
    eff_nxt = run_q;
    if (auto_gate) begin
      case (mode_nxt)
        ST_SLEEP: begin
          eff_nxt = sleep_q;
        end
        ST_DEEP: begin
          eff_nxt = deep_q;
        end
        default: begin
          eff_nxt = run_q;
        end
      endcase
    end
  end

  // Access to an unclocked unit faults
  assign fault_ev = unit_access & ~unit_clk_en_r & `DSPCG_GATE_MASK;

  // Only the named gate bits ever reach a unit
  always @* begin
    gate_nxt = `DSPCG_ZERO;
    gate_nxt[`DSPCG_BIT_ACMP2] = eff_nxt[`DSPCG_BIT_ACMP2];
    gate_nxt[`DSPCG_BIT_ACMP1] = eff_nxt[`DSPCG_BIT_ACMP1];
    gate_nxt[`DSPCG_BIT_ACMP0] = eff_nxt[`DSPCG_BIT_ACMP0];
    gate_nxt[`DSPCG_BIT_TMR2] = eff_nxt[`DSPCG_BIT_TMR2];
    gate_nxt[`DSPCG_BIT_TMR1] = eff_nxt[`DSPCG_BIT_TMR1];
    gate_nxt[`DSPCG_BIT_TMR0] = eff_nxt[`DSPCG_BIT_TMR0];
    gate_nxt[`DSPCG_BIT_TWB] = eff_nxt[`DSPCG_BIT_TWB];
    gate_nxt[`DSPCG_BIT_SSER] = eff_nxt[`DSPCG_BIT_SSER];
    gate_nxt[`DSPCG_BIT_ASER1] = eff_nxt[`DSPCG_BIT_ASER1];
    gate_nxt[`DSPCG_BIT_ASER0] = eff_nxt[`DSPCG_BIT_ASER0];
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r <= ST_RUN;
    end else if (hce) begin
      mode_r <= mode_nxt;
    end
  end

  // A set bit runs the unit clock, a clear bit stops it
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_clk_en_r <= `DSPCG_GATE_RST;
    end else if (hce) begin
      unit_clk_en_r <= gate_nxt;
    end
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      unit_fault_r <= 1'b0;
    end else if (hce) begin
      unit_fault_r <= |fault_ev;
    end
  end

  // Faults on gated units feed the sticky status
  dspcg_irq u_irq (
    .hclk(hclk),
    .hresetn(hresetn),
    .ce(hce),
    .ev(fault_ev),
    .clr_we(wr_iclr),
    .en_we(wr_ien),
    .wdata(hwdata),
    .stat_r(stat_q),
    .en_r(ien_q),
    .irq_r(irq_w)
  );

  // Output stage so the interrupt leaves from a flop
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_r <= 1'b0;
    end else if (hce) begin
      irq_r <= irq_w;
    end
  end

  // Read mux; unmapped and write-only addresses read zero
  always @* begin
    case (addr_r)
      `DSPCG_OFS_CFG: begin
        rd_mux = cfg_r;
      end
      `DSPCG_OFS_RUN: begin
        rd_mux = run_q;
      end
      `DSPCG_OFS_SLEEP: begin
        rd_mux = sleep_q;
      end
      `DSPCG_OFS_DEEP: begin
        rd_mux = deep_q;
      end
      `DSPCG_OFS_STAT: begin
        rd_mux = stat_q;
      end
      `DSPCG_OFS_IEN: begin
        rd_mux = ien_q;
      end
      `DSPCG_OFS_MODE: begin
        rd_mux = {30'h0000_0000, mode_r};
      end
      `DSPCG_OFS_EFF: begin
        rd_mux = unit_clk_en_r;
      end
      default: begin
        rd_mux = `DSPCG_ZERO;
      end
    endcase
  end

endmodule // dspcg_top
